/* File: core/sp_cfg.svh */
// constants for the serial port block
//
// Contract
// - start requested on a busy bus is held until the bus is released
// - multi-master transmitter start on busy bus waits in an idle state
// - while waiting, clock activity may raise tx empty; written bytes are dropped
// - start seen, stop seen and not acked flags clear by hardware on bus events
// - irq pends when a flag and its enable are both one
// - spi slave phase one: later bytes go out shifted one bit
`ifndef SP_CFG_SVH
`define SP_CFG_SVH
`define SP_CLK_HZ 50000000
`define SP_SCL_MAX_HZ 50000
`define SP_SCL_MIN_HALF_NS 10000
`define SP_SCL_HALF_CYC ((`SP_SCL_MIN_HALF_NS * 50 + 999) / 1000)
`define SP_FIFO_DEPTH 16
`define SP_DATA_W 8
`endif

/* File: core/sp_pkg.sv */
// types for the serial port block
package sp_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_WAIT_FREE = 3'b001,
      ST_START = 3'b010,
      ST_SHIFT = 3'b011,
      ST_ACK = 3'b100,
      ST_STOP = 3'b101
   } i2c_state_t;
endpackage

/* File: core/sp_stream_if.sv */
// stream interface between the top and its fifo
`timescale 1ns/1ns
interface sp_stream_if #(parameter int W = 8);
   logic [W-1:0] data;
   logic valid;
   logic ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface

/* File: core/sp_fifo.sv */
// parameterised flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ns
module sp_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic nrst,
   sp_stream_if.snk in_s,
   sp_stream_if.src out_s
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   wire push = in_s.valid && in_s.ready;
   wire pop = out_s.valid && out_s.ready;
   assign in_s.ready = (cnt_q != (AW+1)'(DEPTH));
   assign out_s.valid = (cnt_q != '0);
   assign out_s.data = mem_q[rd_q];
   // storage
   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_q] <= in_s.data;
      end
   end
   // pointers and fill count
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
         if (pop) rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

/* File: core/sp_core.sv */
// i2c multi-master transmitter and spi slave with documented defects
`timescale 1ns/1ns
`include "sp_cfg.svh"
module sp_core #(
   parameter int W = `SP_DATA_W,
   parameter int DEPTH = `SP_FIFO_DEPTH,
   parameter int HALF = `SP_SCL_HALF_CYC
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic multi_master_select,
   input wire logic transmitter_select,
   input wire logic start_req_set,
   input wire logic stop_req_set,
   input wire logic [6:0] slave_addr,
   input wire logic [W-1:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   output logic start_request_bit,
   output logic stop_request_bit,
   output logic bus_occupied_flag,
   output logic tx_empty_flag,
   output logic [W-1:0] tx_dropped_cnt,
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic start_seen_irq_enable,
   input wire logic stop_seen_irq_enable,
   input wire logic not_acked_irq_enable,
   input wire logic flag_set_start,
   input wire logic flag_set_stop,
   input wire logic flag_set_nack,
   output logic start_seen_flag,
   output logic stop_seen_flag,
   output logic not_acked_flag,
   output logic unit_irq_flag,
   input wire logic clock_phase_select,
   input wire logic msb_first_select,
   input wire logic spi_tx_wr,
   input wire logic [W-1:0] spi_tx_wdata,
   output logic [W-1:0] spi_transmit_buffer,
   input wire logic spi_sck,
   input wire logic spi_cs_n,
   input wire logic spi_mosi,
   output logic spi_miso,
   output logic [W-1:0] spi_rx_data,
   output logic spi_rx_done
);
   // three-stage samplers; scl, sda, sck and cs changes accepted when stages two and three agree
   logic [2:0] scl_s_q, sda_s_q, sck_s_q, cs_s_q, mosi_s_q;
   logic scl_f_q, sda_f_q, sck_f_q, cs_f_q;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         scl_s_q <= 3'h7;
         sda_s_q <= 3'h7;
         sck_s_q <= 3'h0;
         cs_s_q <= 3'h7;
         mosi_s_q <= 3'h0;
      end else begin
         scl_s_q <= {scl_s_q[1:0], scl_in};
         sda_s_q <= {sda_s_q[1:0], sda_in};
         sck_s_q <= {sck_s_q[1:0], spi_sck};
         cs_s_q <= {cs_s_q[1:0], spi_cs_n};
         mosi_s_q <= {mosi_s_q[1:0], spi_mosi};
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         scl_f_q <= 1'b1;
         sda_f_q <= 1'b1;
         sck_f_q <= 1'b0;
         cs_f_q <= 1'b1;
      end else begin
         if (scl_s_q[1] == scl_s_q[2]) scl_f_q <= scl_s_q[2];
         if (sda_s_q[1] == sda_s_q[2]) sda_f_q <= sda_s_q[2];
         if (sck_s_q[1] == sck_s_q[2]) sck_f_q <= sck_s_q[2];
         if (cs_s_q[1] == cs_s_q[2]) cs_f_q <= cs_s_q[2];
      end
   end
   wire scl_stable = (scl_s_q[1] == scl_s_q[2]);
   wire sda_stable = (sda_s_q[1] == sda_s_q[2]);
   wire scl_rise = scl_stable && scl_s_q[2] && !scl_f_q;
   wire bus_start_ev = sda_stable && !sda_s_q[2] && sda_f_q && scl_f_q && scl_stable && scl_s_q[2];
   wire bus_stop_ev = sda_stable && sda_s_q[2] && !sda_f_q && scl_f_q && scl_stable && scl_s_q[2];
   wire sck_rise = (sck_s_q[1] == sck_s_q[2]) && sck_s_q[2] && !sck_f_q;
   wire sck_fall = (sck_s_q[1] == sck_s_q[2]) && !sck_s_q[2] && sck_f_q;
   wire cs_act = !cs_f_q;

   // transmit fifo
   sp_stream_if #(.W(W)) fin_s ();
   sp_stream_if #(.W(W)) fout_s ();
   sp_fifo #(.W(W), .DEPTH(DEPTH)) u_fifo (.clk(clk), .nrst(nrst), .in_s(fin_s), .out_s(fout_s));

   // i2c master state
   sp_pkg::i2c_state_t st_q;
   logic [$clog2(HALF+1)-1:0] div_q;
   logic [3:0] bit_q;
   logic [8:0] sh_q;
   logic phase_q, addr_ph_q, busy_q, own_q, flag_nack_hw;
   wire tick = (div_q == '0);
   wire waiting = (st_q == sp_pkg::ST_WAIT_FREE);
   wire wait_mm = waiting && multi_master_select && transmitter_select;
   assign fin_s.data = tx_data;
   assign fin_s.valid = tx_valid && !wait_mm;
   assign fout_s.ready = tick && phase_q && (st_q == sp_pkg::ST_ACK) && !addr_ph_q && !stop_request_bit;

   // other masters' traffic marks the bus occupied
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) busy_q <= 1'b0;
      else if (bus_start_ev) busy_q <= 1'b1;
      else if (bus_stop_ev) busy_q <= 1'b0;
   end
   wire foreign_busy = busy_q && !own_q;

   // master sequencer: wait for free bus, start, address, data bytes, stop
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_q <= sp_pkg::ST_IDLE;
         div_q <= '0;
         bit_q <= 4'h0;
         sh_q <= 9'h1FF;
         phase_q <= 1'b0;
         addr_ph_q <= 1'b0;
         own_q <= 1'b0;
         start_request_bit <= 1'b0;
         stop_request_bit <= 1'b0;
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
         flag_nack_hw <= 1'b0;
      end else begin
         flag_nack_hw <= 1'b0;
         div_q <= tick ? ($clog2(HALF+1))'(HALF - 1) : div_q - 1'b1;
         if (start_req_set) start_request_bit <= 1'b1;
         if (stop_req_set) stop_request_bit <= 1'b1;
         case (st_q)
            sp_pkg::ST_IDLE: begin
               if (start_req_set || start_request_bit) st_q <= sp_pkg::ST_WAIT_FREE;
            end
            sp_pkg::ST_WAIT_FREE: begin
               // the visible busy flag lags busy_q by a cycle; wait for both so the start never beats it
               if (!foreign_busy && !bus_occupied_flag && tick) begin
                  sda_oe <= 1'b1;
                  own_q <= 1'b1;
                  st_q <= sp_pkg::ST_START;
               end
            end
            sp_pkg::ST_START: if (tick) begin
               scl_oe <= 1'b1;
               start_request_bit <= 1'b0;
               sh_q <= {slave_addr, !transmitter_select, 1'b1};
               bit_q <= 4'h0;
               addr_ph_q <= 1'b1;
               phase_q <= 1'b0;
               st_q <= sp_pkg::ST_SHIFT;
            end
            sp_pkg::ST_SHIFT: if (tick) begin
               phase_q <= !phase_q;
               scl_oe <= phase_q;
               if (!phase_q) sda_oe <= !sh_q[8];
               else begin
                  sh_q <= {sh_q[7:0], 1'b1};
                  bit_q <= bit_q + 4'h1;
                  if (bit_q == 4'h7) st_q <= sp_pkg::ST_ACK;
               end
            end
            sp_pkg::ST_ACK: if (tick) begin
               phase_q <= !phase_q;
               scl_oe <= phase_q;
               if (!phase_q) sda_oe <= 1'b0;
               else begin
                  bit_q <= 4'h0;
                  addr_ph_q <= 1'b0;
                  if (sda_f_q) begin
                     flag_nack_hw <= 1'b1;
                     st_q <= sp_pkg::ST_STOP;
                  end else if (stop_request_bit || !fout_s.valid) begin
                     st_q <= sp_pkg::ST_STOP;
                  end else begin
                     sh_q <= {fout_s.data, 1'b1};
                     st_q <= sp_pkg::ST_SHIFT;
                  end
               end
            end
            sp_pkg::ST_STOP: if (tick) begin
               phase_q <= !phase_q;
               if (!phase_q) begin
                  sda_oe <= 1'b1;
                  scl_oe <= 1'b0;
               end else begin
                  sda_oe <= 1'b0;
                  own_q <= 1'b0;
                  stop_request_bit <= 1'b0;
                  st_q <= sp_pkg::ST_IDLE;
               end
            end
            default: st_q <= sp_pkg::ST_IDLE;
         endcase
      end
   end
   // open-drain data levels: the pins only ever pull low
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         scl_out <= 1'b0;
         sda_out <= 1'b0;
      end else begin
         scl_out <= 1'b0;
         sda_out <= 1'b0;
      end
   end

   // transmit empty flag and dropped-byte count
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tx_empty_flag <= 1'b1;
         tx_dropped_cnt <= '0;
         tx_ready <= 1'b1;
      end else begin
         tx_ready <= fin_s.ready;
         if (wait_mm && scl_rise) tx_empty_flag <= 1'b1;
         else if (fin_s.valid && fin_s.ready) tx_empty_flag <= 1'b0;
         else if (!fout_s.valid) tx_empty_flag <= 1'b1;
         if (wait_mm && tx_valid) tx_dropped_cnt <= tx_dropped_cnt + 1'b1;
      end
   end

   // self-clearing flags: set by software, cleared by bus events; set wins
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         start_seen_flag <= 1'b0;
         stop_seen_flag <= 1'b0;
         not_acked_flag <= 1'b0;
         unit_irq_flag <= 1'b0;
         bus_occupied_flag <= 1'b0;
      end else begin
         bus_occupied_flag <= busy_q;
         if (flag_set_start) start_seen_flag <= 1'b1;
         else if (bus_stop_ev) start_seen_flag <= 1'b0;
         if (flag_set_stop) stop_seen_flag <= 1'b1;
         else if (bus_start_ev) stop_seen_flag <= 1'b0;
         if (flag_set_nack || flag_nack_hw) not_acked_flag <= 1'b1;
         else if (bus_start_ev) not_acked_flag <= 1'b0;
         unit_irq_flag <= (start_seen_flag && start_seen_irq_enable) || (stop_seen_flag && stop_seen_irq_enable)
            || (not_acked_flag && not_acked_irq_enable);
      end
   end

   // spi slave: buffer write preloads shifter at once, rx completes a byte
   logic [W-1:0] spi_sh_q, spi_rx_q;
   logic [3:0] spi_bit_q;
   logic spi_used_q; // a byte has completed since the last buffer write
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         spi_transmit_buffer <= '0;
         spi_sh_q <= '0;
         spi_rx_q <= '0;
         spi_bit_q <= 4'h0;
         spi_rx_data <= '0;
         spi_rx_done <= 1'b0;
         spi_miso <= 1'b0;
         spi_used_q <= 1'b0;
      end else begin
         spi_rx_done <= 1'b0;
         spi_miso <= msb_first_select ? spi_sh_q[W-1] : spi_sh_q[0];
         if (spi_tx_wr) begin
            spi_transmit_buffer <= spi_tx_wdata;
            spi_sh_q <= spi_tx_wdata;
         end else if (cs_act && (clock_phase_select ? sck_fall : sck_rise) && spi_bit_q != 4'h0) begin
            spi_sh_q <= msb_first_select ? {spi_sh_q[W-2:0], 1'b0} : {1'b0, spi_sh_q[W-1:1]};
         end else if (cs_act && clock_phase_select && sck_rise && spi_bit_q == 4'h0 && spi_used_q) begin
            spi_sh_q <= msb_first_select ? {spi_sh_q[W-2:0], 1'b0} : {1'b0, spi_sh_q[W-1:1]};
         end
         if (!cs_act) spi_bit_q <= 4'h0;
         else if (clock_phase_select ? sck_rise : sck_rise) begin
            spi_rx_q <= msb_first_select ? {spi_rx_q[W-2:0], mosi_s_q[2]} : {mosi_s_q[2], spi_rx_q[W-1:1]};
            if (spi_bit_q == 4'(W-1)) begin
               spi_bit_q <= 4'h0;
               spi_rx_done <= 1'b1;
               spi_used_q <= 1'b1;
               spi_rx_data <= msb_first_select ? {spi_rx_q[W-2:0], mosi_s_q[2]} : {mosi_s_q[2], spi_rx_q[W-1:1]};
            end else begin
               spi_bit_q <= spi_bit_q + 4'h1;
            end
         end
         if (spi_tx_wr) spi_used_q <= 1'b0; // fresh buffer: next byte goes out unshifted
      end
   end
endmodule

/* File: tb/sp_core_asserts.sv */
// concurrent checks on the serial port block ports
`timescale 1ns/1ns
module sp_core_asserts #(parameter int W = 8) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic multi_master_select,
   input wire logic transmitter_select,
   input wire logic start_req_set,
   input wire logic flag_set_start,
   input wire logic flag_set_stop,
   input wire logic flag_set_nack,
   input wire logic tx_valid,
   input wire logic start_request_bit,
   input wire logic bus_occupied_flag,
   input wire logic [W-1:0] tx_dropped_cnt,
   input wire logic scl_oe,
   input wire logic sda_oe,
   input wire logic start_seen_irq_enable,
   input wire logic stop_seen_irq_enable,
   input wire logic not_acked_irq_enable,
   input wire logic start_seen_flag,
   input wire logic stop_seen_flag,
   input wire logic not_acked_flag,
   input wire logic unit_irq_flag
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // pending start held on a busy bus for two cycles running
   sequence s_wait;
      (start_request_bit && bus_occupied_flag) ##1
      (multi_master_select && transmitter_select && start_request_bit && bus_occupied_flag && !sda_oe);
   endsequence
   property p_req_held;
      start_req_set |=> start_request_bit;
   endproperty
   property p_no_start;
      start_request_bit && bus_occupied_flag && !sda_oe |=> !sda_oe;
   endproperty
   property p_wait_quiet;
      s_wait |-> !scl_oe;
   endproperty
   property p_drop;
      s_wait ##0 tx_valid |=> tx_dropped_cnt == $past(tx_dropped_cnt) + 1'b1;
   endproperty
   property p_stop_clr;
      $rose(bus_occupied_flag) && !flag_set_stop |-> ##[0:3] !stop_seen_flag;
   endproperty
   property p_nack_clr;
      $rose(bus_occupied_flag) && !flag_set_nack |-> ##[0:3] !not_acked_flag;
   endproperty
   property p_start_clr;
      $fell(bus_occupied_flag) && !flag_set_start |-> ##[0:3] !start_seen_flag;
   endproperty
   property p_irq;
      1'b1 |=> unit_irq_flag == $past((start_seen_flag && start_seen_irq_enable) ||
         (stop_seen_flag && stop_seen_irq_enable) || (not_acked_flag && not_acked_irq_enable));
   endproperty
   a_req_held: assert property (p_req_held)
      else $error("start request not held");
   a_no_start: assert property (p_no_start)
      else $error("start driven on busy bus");
   a_wait_quiet: assert property (p_wait_quiet)
      else $error("clock driven while waiting");
   a_drop: assert property (p_drop)
      else $error("byte during wait not counted");
   a_stop_clr: assert property (p_stop_clr)
      else $error("stop flag kept after start");
   a_nack_clr: assert property (p_nack_clr)
      else $error("nack flag kept after start");
   a_start_clr: assert property (p_start_clr)
      else $error("start flag kept after stop");
   a_irq: assert property (p_irq)
      else $error("irq flag wrong");
endmodule
bind sp_core sp_core_asserts #(.W(W)) u_chk (.clk, .nrst, .multi_master_select, .transmitter_select,
   .start_req_set, .flag_set_start, .flag_set_stop, .flag_set_nack, .tx_valid, .start_request_bit,
   .bus_occupied_flag, .tx_dropped_cnt, .scl_oe, .sda_oe, .start_seen_irq_enable, .stop_seen_irq_enable,
   .not_acked_irq_enable, .start_seen_flag, .stop_seen_flag, .not_acked_flag, .unit_irq_flag);

/* File: tb/i2c_peer.sv */
// another master sharing the i2c bus through open-drain pulls
`timescale 1ns/1ns
module i2c_peer (
   output logic scl_pull,
   output logic sda_pull
);
   // both lines released to the pull-up at start
   initial begin
      scl_pull = 1'b0;
      sda_pull = 1'b0;
   end
   // start: data falls while clock high, then clock held low
   task automatic bus_start();
      sda_pull = 1'b1;
      #5000 scl_pull = 1'b1;
   endtask
   // slow bit clocks, half period 12.5 us, below the 50 kHz limit
   task automatic bus_clocks(input int n);
      repeat (n) begin
         #12500 scl_pull = 1'b0;
         #12500 scl_pull = 1'b1;
      end
   endtask
   // stop: data rises while clock high
   task automatic bus_stop();
      #5000 scl_pull = 1'b0;
      #5000 sda_pull = 1'b0;
   endtask
endmodule

/* File: tb/tb.sv */
// testbench for the serial port block
`timescale 1ns/1ns
module tb;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic multi_master_select, transmitter_select, start_req_set, tx_valid, start_seen_irq_enable;
   logic stop_seen_irq_enable, not_acked_irq_enable, flag_set_start, flag_set_stop, flag_set_nack;
   logic clock_phase_select, msb_first_select, spi_tx_wr, spi_sck, spi_cs_n, spi_mosi;
   logic [7:0] tx_data, spi_tx_wdata, tx_dropped_cnt, spi_transmit_buffer, spi_rx_data;
   logic tx_ready, start_request_bit, stop_request_bit, bus_occupied_flag, tx_empty_flag, scl_out, scl_oe;
   logic sda_out, sda_oe, start_seen_flag, stop_seen_flag, not_acked_flag, unit_irq_flag, spi_miso;
   logic spi_rx_done, scl_pull, sda_pull;
   wire scl = !(scl_oe || scl_pull);
   wire sda = !(sda_oe || sda_pull);
   int n_mismatch = 0;
   int samples_checked = 0;
   int n_done = 0;
   // count completed spi bytes away from the launching edge
   always @(negedge clk) if (spi_rx_done === 1'b1) n_done++;
   sp_core #(.HALF(4)) dut (.clk, .nrst, .multi_master_select, .transmitter_select, .start_req_set,
      .stop_req_set(1'b0), .slave_addr(7'h2A), .tx_data, .tx_valid, .tx_ready, .start_request_bit,
      .stop_request_bit, .bus_occupied_flag, .tx_empty_flag, .tx_dropped_cnt, .scl_in(scl), .scl_out,
      .scl_oe, .sda_in(sda), .sda_out, .sda_oe, .start_seen_irq_enable, .stop_seen_irq_enable,
      .not_acked_irq_enable, .flag_set_start, .flag_set_stop, .flag_set_nack, .start_seen_flag,
      .stop_seen_flag, .not_acked_flag, .unit_irq_flag, .clock_phase_select, .msb_first_select,
      .spi_tx_wr, .spi_tx_wdata, .spi_transmit_buffer, .spi_sck, .spi_cs_n, .spi_mosi, .spi_miso,
      .spi_rx_data, .spi_rx_done);
   i2c_peer peer (.scl_pull, .sda_pull);
   always #10 clk = ~clk;
   // wait n edges, then step off the edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      tick(1);
      s = 1'b0;
   endtask
   // spi frame as master, data changes on the leading edge
   task automatic spi_xfer(input logic [7:0] b);
      spi_cs_n = 1'b0;
      #83;
      for (int i = 0; i < 8; i++) begin
         spi_mosi = msb_first_select ? b[7-i] : b[i];
         spi_sck = 1'b1;
         #80 spi_sck = 1'b0;
         #80;
      end
      spi_cs_n = 1'b1;
      tick(8);
      chk(spi_rx_data, b);
   endtask
   // hang guard
   initial begin
      repeat (100000) @(posedge clk);
      n_mismatch++;
      $display("BAD %0t run too long", $time);
      wrap_up();
   end
   initial begin
      {multi_master_select, transmitter_select, start_req_set, tx_valid, start_seen_irq_enable} = 5'h18;
      {stop_seen_irq_enable, not_acked_irq_enable, flag_set_start, flag_set_stop, flag_set_nack} = 5'h00;
      {clock_phase_select, msb_first_select, spi_tx_wr, spi_sck, spi_cs_n, spi_mosi} = 6'h02;
      tx_data = 8'h00;
      spi_tx_wdata = 8'h00;
      tick(4);
      nrst = 1'b1;
      tick(2);
      // flags and irq
      chk(8'({scl_out, sda_out}), 8'h00);
      start_seen_irq_enable = 1'b1;
      pulse(flag_set_start);
      tick(2);
      chk(unit_irq_flag, 1'b1);
      start_seen_irq_enable = 1'b0;
      tick(2);
      chk(unit_irq_flag, 1'b0);
      pulse(flag_set_stop);
      pulse(flag_set_nack);
      $display("flags test done");
      // start requested while the peer holds the bus
      chk(bus_occupied_flag, 1'b0);
      peer.bus_start();
      tick(8);
      chk(bus_occupied_flag, 1'b1);
      chk(stop_seen_flag, 1'b0);
      chk(not_acked_flag, 1'b0);
      pulse(start_req_set);
      tick(1);
      tx_data = 8'h5A;
      tx_valid = 1'b1;
      tick(3);
      tx_valid = 1'b0;
      peer.bus_clocks(3);
      tick(1);
      chk(tx_dropped_cnt, 8'h03);
      chk(start_request_bit, 1'b1);
      chk(sda_oe, 1'b0);
      pulse(flag_set_start);
      peer.bus_stop();
      tick(8);
      chk(start_seen_flag, 1'b0);
      for (int i = 0; i < 2000 && start_request_bit !== 1'b0; i++) tick(1);
      chk(start_request_bit, 1'b0);
      $display("busy bus test done");
      // fifo fill until refused
      nrst = 1'b0;
      multi_master_select = 1'b0;
      tick(4);
      nrst = 1'b1;
      tick(2);
      tx_valid = 1'b1;
      tick(15);
      chk(tx_ready, 1'b1);
      tick(5);
      chk(tx_ready, 1'b0);
      tx_valid = 1'b0;
      tick(1);
      chk(tx_empty_flag, 1'b0);
      // clock activity while waiting raises tx empty even with a full fifo
      multi_master_select = 1'b1;
      peer.bus_start();
      tick(8);
      pulse(start_req_set);
      peer.bus_clocks(1);
      tick(4);
      chk(tx_empty_flag, 1'b1);
      chk(start_request_bit, 1'b1);
      nrst = 1'b0;
      peer.bus_stop();
      nrst = 1'b1;
      tick(2);
      $display("fifo test done");
      // spi slave phase one, both bit orders
      clock_phase_select = 1'b1;
      for (int m = 0; m < 2; m++) begin
         msb_first_select = m[0];
         spi_tx_wdata = 8'hC3;
         pulse(spi_tx_wr);
         chk(spi_transmit_buffer, 8'hC3);
         tick(1);
         chk(spi_miso, 1'b1);
         spi_xfer(8'h96);
         spi_tx_wdata = spi_transmit_buffer;
         pulse(spi_tx_wr);
         tick(1);
      end
      chk(8'(n_done), 8'h02);
      $display("spi test done");
      wrap_up();
   end
endmodule
